//--- shared/jkms_pkg.sv
/*
  Constants and types shared by the master-slave J-K storage element and
  its pin synchroniser.
  Assumes a single system clock domain; all pin inputs are asynchronous.
*/
package jkms_pkg;

  // ----------------------------------------------------------------
  // Element variants
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    VARIANT_LEVEL   = 2'b00,
    VARIANT_EDGE    = 2'b01,
    VARIANT_SPECIAL = 2'b10
  } jkms_variant_e;

  // ----------------------------------------------------------------
  // Pin bundle layout fed through the synchroniser
  // ----------------------------------------------------------------
  localparam int PIN_W = 6;
  localparam int PIN_DRST = 0;
  localparam int PIN_DSET = 1;
  localparam int PIN_PULSE = 2;
  localparam int PIN_CLR = 3;
  localparam int PIN_SET = 4;
  localparam int PIN_D = 5;
  // Direct set/reset idle high, everything else idles low
  localparam logic [PIN_W-1:0] PIN_RST_VAL = 6'h03;

  // ----------------------------------------------------------------
  // Reset values and synchroniser depth
  // ----------------------------------------------------------------
  localparam logic MAIN_RST = 1'b0;
  localparam logic COMP_RST = 1'b1;
  localparam logic PULSE_RST = 1'b0;
  localparam int SYNC_STAGES_DEF = 2;
  localparam int SYNC_STAGES_MIN = 2;

endpackage : jkms_pkg

//--- src/jkms_sync.sv
/*
  Multi-bit level synchroniser: each bit passes STAGES flip-flops.
  Assumes bits are independent levels; no word coherence is promised.
*/
`timescale 1ns/1ps
module jkms_sync
  import jkms_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter int STAGES = SYNC_STAGES_DEF,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (STAGES < SYNC_STAGES_MIN) begin : g_stage_chk
    $error("jkms_sync needs at least two stages");
  end

  // ----------------------------------------------------------------
  // Stage chain
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] stage_r [STAGES];

  // First stage is read only by the second; clock enable freezes all
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_r[i] <= RST_VAL;
      end
    end else if (ce) begin
      stage_r[0] <= din;
      for (int i = 1; i < STAGES; i++) begin
        stage_r[i] <= stage_r[i-1];
      end
    end
  end

  assign dout = stage_r[STAGES-1];

endmodule : jkms_sync

//--- src/jkms_flip_flop.sv
/*
  Synchronous model of a master-slave J-K storage element with direct
  set/reset, a D-input option, and level, edge and special variants.
  Assumes all pin inputs are asynchronous to mclk and are synchronised
  here; variant_sel and d_mode come from logic on mclk and are static.
*/
`timescale 1ns/1ps
module jkms_flip_flop
  import jkms_pkg::*;
#(
  parameter int SYNC_STAGES = SYNC_STAGES_DEF
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [1:0] variant_sel,
  input wire logic d_mode,
  input wire logic d_in,
  input wire logic prep_set,
  input wire logic prep_clear,
  input wire logic pulse_in,
  input wire logic direct_set_n,
  input wire logic direct_reset_n,
  output logic main_out,
  output logic comp_out,
  output logic master_main,
  output logic master_comp
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (SYNC_STAGES < SYNC_STAGES_MIN) begin : g_param_chk
    $error("jkms_flip_flop needs SYNC_STAGES of two or more");
  end

  // ----------------------------------------------------------------
  // Truth table of the preparatory inputs
  // ----------------------------------------------------------------
  // Next main level for a given set/clear pair and present level
  function automatic logic jk_next(input logic j, input logic k, input logic q);
    logic r;
    r = q;
    if (j && k) begin
      r = ~q;
    end else if (j) begin
      r = 1'b1;
    end else if (k) begin
      r = 1'b0;
    end
    return r;
  endfunction : jk_next

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s;
  jkms_variant_e var_w;
  logic d_s;
  logic set_s;
  logic clr_s;
  logic t_s;
  logic ovr_set;
  logic ovr_clr;
  logic ovr_w;
  logic j_w;
  logic k_w;
  logic set_term;
  logic clear_term;
  logic x_gate;
  logic fall_w;
  logic slave_load;
  logic t_prev_r;
  logic master_main_r;
  logic master_main_nxt;
  logic master_comp_r;
  logic master_comp_nxt;
  logic main_r;
  logic main_nxt;
  logic comp_r;
  logic comp_nxt;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  // Every pin crosses SYNC_STAGES flops, so direct set/reset also lag by the
  // synchroniser depth; the price of keeping all state on one clock
  assign pins_raw = {d_in, prep_set, prep_clear, pulse_in, direct_set_n, direct_reset_n};

  jkms_sync #(
    .WIDTH(PIN_W),
    .STAGES(SYNC_STAGES),
    .RST_VAL(PIN_RST_VAL)
  ) u_pin_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .din(pins_raw),
    .dout(pins_s)
  );

  assign d_s = pins_s[PIN_D];
  assign set_s = pins_s[PIN_SET];
  assign clr_s = pins_s[PIN_CLR];
  assign t_s = pins_s[PIN_PULSE];
  assign ovr_set = ~pins_s[PIN_DSET];
  assign ovr_clr = ~pins_s[PIN_DRST];
  assign ovr_w = ovr_set | ovr_clr;

  // ----------------------------------------------------------------
  // Variant decode and preparatory terms
  // ----------------------------------------------------------------
  // The unused code falls back to the level variant
  always_comb begin
    case (variant_sel)
      VARIANT_EDGE: var_w = VARIANT_EDGE;
      VARIANT_SPECIAL: var_w = VARIANT_SPECIAL;
      default: var_w = VARIANT_LEVEL;
    endcase
  end

  // D option forces the two preparatory terms to be complements
  assign j_w = d_mode ? d_s : set_s;
  assign k_w = d_mode ? ~d_s : clr_s;

  // Crossed feedback: each term is gated by the opposite slave output
  assign set_term = j_w & comp_r;
  assign clear_term = k_w & main_r;
  assign x_gate = ~set_term & ~clear_term;

  // ----------------------------------------------------------------
  // Pulse edge tracking
  // ----------------------------------------------------------------
  // Previous pulse level, for falling edge detection on mclk
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      t_prev_r <= PULSE_RST;
    end else if (ce) begin
      t_prev_r <= t_s;
    end
  end

  assign fall_w = t_prev_r & ~t_s;

  // Slave takes the master on the fall; the special variant may also
  // take it whenever its slave gate is open
  assign slave_load = fall_w || ((var_w == VARIANT_SPECIAL) && x_gate);

  // ----------------------------------------------------------------
  // Master stage
  // ----------------------------------------------------------------
  // Level and special masters are non-volatile: once a term flips them
  // they stay until the slave takes them. The edge master is volatile and simply
  // tracks the outcome of the present inputs while the pulse is high.
  always_comb begin
    master_main_nxt = master_main_r;
    master_comp_nxt = master_comp_r;
    if (ovr_w) begin
      master_main_nxt = ovr_set;
      master_comp_nxt = ovr_clr;
    end else if (t_s) begin
      case (var_w)
        VARIANT_EDGE: begin
          master_main_nxt = jk_next(j_w, k_w, main_r);
        end
        default: begin
          if (set_term) begin
            master_main_nxt = 1'b1;
          end else if (clear_term) begin
            master_main_nxt = 1'b0;
          end
        end
      endcase
      master_comp_nxt = ~master_main_nxt;
    end
  end

  // Master register update
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      master_main_r <= MAIN_RST;
      master_comp_r <= COMP_RST;
    end else if (ce) begin
      master_main_r <= master_main_nxt;
      master_comp_r <= master_comp_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Slave stage
  // ----------------------------------------------------------------
  // Both direct inputs low drives both outputs high; once released the
  // complement realigns to the inverse of the main output
  always_comb begin
    main_nxt = main_r;
    if (ovr_w) begin
      main_nxt = ovr_set;
      comp_nxt = ovr_clr;
    end else begin
      if (slave_load) begin
        main_nxt = master_main_r;
      end
      comp_nxt = ~main_nxt;
    end
  end

  // Slave register update; a closed slave gate simply holds
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      main_r <= MAIN_RST;
      comp_r <= COMP_RST;
    end else if (ce) begin
      main_r <= main_nxt;
      comp_r <= comp_nxt;
    end
  end

  assign main_out = main_r;
  assign comp_out = comp_r;
  assign master_main = master_main_r;
  assign master_comp = master_comp_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb_main @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // Set-side input falls alone; a tied fall of both is a toggle instead
  sequence s_set_fall;
    (ce && !ovr_w && var_w == VARIANT_SPECIAL && t_s && j_w)
    ##1 (ce && !ovr_w && var_w == VARIANT_SPECIAL && t_s && !j_w && $stable(k_w));
  endsequence

  // Clear-side input falls alone; a tied fall of both is a toggle instead
  sequence s_clr_fall;
    (ce && !ovr_w && var_w == VARIANT_SPECIAL && t_s && k_w)
    ##1 (ce && !ovr_w && var_w == VARIANT_SPECIAL && t_s && !k_w && $stable(j_w));
  endsequence

  // Edge variant, both inputs high on the last high cycle, then the fall
  sequence s_edge_toggle;
    (ce && !ovr_w && var_w == VARIANT_EDGE && t_s && j_w && k_w)
    ##1 (ce && !ovr_w && fall_w);
  endsequence

  // Edge variant in D mode with data high on the last high cycle
  sequence s_edge_d_high;
    (ce && !ovr_w && var_w == VARIANT_EDGE && d_mode && t_s && d_s)
    ##1 (ce && !ovr_w && fall_w);
  endsequence

  // Level variant, change term active, then the fall
  sequence s_level_change;
    (ce && !ovr_w && var_w == VARIANT_LEVEL && t_s && set_term)
    ##1 (ce && !ovr_w && var_w == VARIANT_LEVEL && fall_w);
  endsequence

  a_dset_force: assert property (
    (ce && ovr_set && !ovr_clr) |=> (main_out && !comp_out)
  ) else $error("direct set did not force main high");

  a_drst_force: assert property (
    (ce && ovr_clr && !ovr_set) |=> (!main_out && comp_out)
  ) else $error("direct reset did not force main low");

  a_slave_takeover: assert property (
    (ce && !ovr_w && fall_w) |=> (main_out == $past(master_main_r))
  ) else $error("slave did not take master state on pulse fall");

  a_comp_track: assert property (
    $past(ce && !ovr_w && rst_n) |-> (comp_out != main_out)
  ) else $error("complement output not inverse of main");

  a_edge_toggle: assert property (
    s_edge_toggle |=> (main_out != $past(main_out))
  ) else $error("edge variant failed to toggle");

  a_edge_d_high: assert property (
    s_edge_d_high |=> (main_out && !comp_out)
  ) else $error("D option high did not set output");

  a_level_change: assert property (
    s_level_change |=> main_out
  ) else $error("late change term did not flip output");

  a_set_fall_sets: assert property (
    s_set_fall |=> (main_out && !comp_out)
  ) else $error("falling set input did not leave main high");

  a_clr_fall_clears: assert property (
    s_clr_fall |=> (!main_out && comp_out)
  ) else $error("falling clear input did not leave main low");

  a_gate_closed_hold: assert property (
    (ce && !ovr_w && var_w == VARIANT_SPECIAL && !x_gate && !fall_w) |=> $stable(main_out)
  ) else $error("slave changed while its gate was closed");

  a_master_idle_hold: assert property (
    (ce && !ovr_w && var_w != VARIANT_EDGE && !set_term && !clear_term)
    |=> $stable(master_main_r)
  ) else $error("master changed with both terms low");

  a_no_pulse_hold: assert property (
    (ce && !ovr_w && var_w != VARIANT_SPECIAL && !fall_w) |=> $stable(main_out)
  ) else $error("output changed without a pulse fall");

endmodule : jkms_flip_flop

//--- verification/jkms_pin_driver.sv
/*
  Model of the surrounding logic that drives the storage element's pins:
  preparatory levels, D level, the trigger pulse and the direct inputs.
  Assumes the same mclk as the element; requests come from the bench.
*/
`timescale 1ns/1ps
module jkms_pin_driver (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic hold_pulse,
  input wire logic j_req,
  input wire logic k_req,
  input wire logic d_req,
  input wire logic force_set,
  input wire logic force_reset,
  output logic busy,
  output logic prep_set,
  output logic prep_clear,
  output logic d_in,
  output logic pulse_in,
  output logic direct_set_n,
  output logic direct_reset_n
);
  logic [3:0] cnt_r;

  // --------------------------------------------------------------
  // Trigger sequence
  // --------------------------------------------------------------
  // Pulse sits mid-window so preparatory levels settle first
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
    end else if (start && cnt_r == 4'h0) begin
      cnt_r <= 4'hc;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
  assign busy = (cnt_r != 4'h0);

  // --------------------------------------------------------------
  // Pin drive
  // --------------------------------------------------------------
  // Registered pins; direct inputs idle high unless forced
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prep_set <= 1'b0;
      prep_clear <= 1'b0;
      d_in <= 1'b0;
      pulse_in <= 1'b0;
      direct_set_n <= 1'b1;
      direct_reset_n <= 1'b1;
    end else begin
      prep_set <= j_req;
      prep_clear <= k_req;
      d_in <= d_req;
      pulse_in <= hold_pulse || (cnt_r >= 4'h5 && cnt_r <= 4'h9);
      direct_set_n <= !force_set;
      direct_reset_n <= !force_reset;
    end
  end
endmodule : jkms_pin_driver

//--- verification/tb.sv
/*
  Self-checking bench for the master-slave storage element.
  Assumes the pin driver model supplies all pins; rows then hand tests.
*/
`timescale 1ns/1ps
module tb;
  import jkms_pkg::*;
  // Row bits: [7:6] variant, [5] d_mode, [4] ce, [3] J, [2] K, [1] D, [0] main
  typedef logic [7:0] jkms_row_t;
  localparam jkms_row_t ROWS [13] = '{8'h19, 8'h11, 8'h1c, 8'h1d, 8'h19, 8'h14,
    8'h5d, 8'h54, 8'h73, 8'h3c, 8'h9d, 8'hdc, 8'h0c};
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [1:0] variant_sel = 2'h0;
  logic d_mode = 1'b0;
  logic start = 1'b0, hold_pulse = 1'b0, j_req = 1'b0, k_req = 1'b0, d_req = 1'b0;
  logic force_set = 1'b0, force_reset = 1'b0, busy;
  logic prep_set, prep_clear, d_in, pulse_in, direct_set_n, direct_reset_n;
  logic main_out, comp_out, master_main, master_comp;
  int failures = 0;
  int n_checks = 0;

  always #10 mclk = ~mclk;

  jkms_pin_driver u_jkms_pin_driver (.mclk(mclk), .rst_n(rst_n), .start(start),
    .hold_pulse(hold_pulse), .j_req(j_req), .k_req(k_req), .d_req(d_req),
    .force_set(force_set), .force_reset(force_reset), .busy(busy),
    .prep_set(prep_set), .prep_clear(prep_clear), .d_in(d_in), .pulse_in(pulse_in),
    .direct_set_n(direct_set_n), .direct_reset_n(direct_reset_n));

  jkms_flip_flop #(.SYNC_STAGES(2)) u_jkms_flip_flop (.mclk(mclk), .rst_n(rst_n),
    .ce(ce), .variant_sel(variant_sel), .d_mode(d_mode), .d_in(d_in),
    .prep_set(prep_set), .prep_clear(prep_clear), .pulse_in(pulse_in),
    .direct_set_n(direct_set_n), .direct_reset_n(direct_reset_n),
    .main_out(main_out), .comp_out(comp_out), .master_main(master_main),
    .master_comp(master_comp));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %b seen %b", nm, exp, got);
    end
  endtask : chk

  // Both stages settled to one value, complements inverse
  task automatic chk_state(input logic m);
    chk("main_out", m, main_out);
    chk("comp_out", !m, comp_out);
    chk("master_main", m, master_main);
    chk("master_comp", !m, master_comp);
  endtask : chk_state

  // Level change on the preparatory pins, then settle
  task automatic set_jk(input logic j, input logic k);
    j_req <= j;
    k_req <= k;
    repeat (6) @(posedge mclk);
  endtask : set_jk

  // One trigger pulse; optional late preparatory change while pulse high
  task automatic trigger(input logic late, input logic lj, input logic lk);
    int i;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    repeat (5) @(posedge mclk);
    if (late) begin
      j_req <= lj;
      k_req <= lk;
    end
    i = 0;
    while (busy !== 1'b0 && i < 40) begin
      @(negedge mclk);
      i++;
    end
    if (i >= 40) begin
      failures++;
      $display("unexpected busy: expected 0 seen 1");
      final_report();
    end
    repeat (4) @(posedge mclk);
  endtask : trigger

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk_state(1'b0);
    // Ordinary cases: each row leaves the state the next row builds on
    foreach (ROWS[r]) begin
      variant_sel <= ROWS[r][7:6];
      d_mode <= ROWS[r][5];
      ce <= ROWS[r][4];
      j_req <= ROWS[r][3];
      k_req <= ROWS[r][2];
      d_req <= ROWS[r][1];
      @(posedge mclk);
      trigger(1'b0, 1'b0, 1'b0);
      ce <= 1'b1;
      @(posedge mclk);
      chk_state(ROWS[r][0]);
    end
    // Late change combination replaces a no-change one in the level variant
    variant_sel <= 2'h0;
    set_jk(1'b0, 1'b0);
    trigger(1'b1, 1'b1, 1'b1);
    chk_state(1'b1);
    // Edge variant: only the late combination counts
    variant_sel <= 2'h1;
    set_jk(1'b1, 1'b1);
    trigger(1'b1, 1'b0, 1'b0);
    chk_state(1'b1);
    // Direct inputs override a clear request and the pulse
    variant_sel <= 2'h0;
    set_jk(1'b0, 1'b1);
    force_reset <= 1'b1;
    trigger(1'b0, 1'b0, 1'b0);
    chk_state(1'b0);
    force_set <= 1'b1;
    repeat (6) @(posedge mclk);
    chk("main_out", 1'b1, main_out);
    chk("comp_out", 1'b1, comp_out);
    force_reset <= 1'b0;
    repeat (6) @(posedge mclk);
    chk_state(1'b1);
    force_set <= 1'b0;
    // Special variant, trigger held high, driven from J and K
    variant_sel <= 2'h2;
    hold_pulse <= 1'b1;
    set_jk(1'b0, 1'b0);
    set_jk(1'b0, 1'b1);
    chk("main_out", 1'b1, main_out);
    set_jk(1'b0, 1'b0);
    chk_state(1'b0);
    set_jk(1'b1, 1'b0);
    chk("main_out", 1'b0, main_out);
    set_jk(1'b0, 1'b0);
    chk_state(1'b1);
    set_jk(1'b1, 1'b0);
    set_jk(1'b0, 1'b0);
    chk_state(1'b1);
    for (int t = 0; t < 2; t++) begin
      set_jk(1'b1, 1'b1);
      chk("main_out", t == 0, main_out);
      set_jk(1'b0, 1'b0);
      chk_state(t != 0);
    end
    hold_pulse <= 1'b0;
    // Second reset in mid-run
    set_jk(1'b0, 1'b0);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk_state(1'b0);
    final_report();
  end
endmodule : tb
